// File: shared/sqw_defs.svh
`ifndef SQW_DEFS_SVH
`define SQW_DEFS_SVH
`define SQW_CLK_NS         100
`define SQW_MS_NS          1000000
`define SQW_SCLK_HALF_NS   800
`define SQW_FRAME_BITS     5'h10
`define SQW_ADDR_METHOD    7'h13
`define SQW_ADDR_PERIOD    7'h14
`define SQW_ADDR_TRIGGER   7'h15
`define SQW_ADDR_PULSE     7'h16
`define SQW_ADDR_QUIZ      7'h2d
`define SQW_ADDR_REPLY     7'h2e
`define SQW_ADDR_PROMPT    7'h2f
`define SQW_F_METHOD       7:6
`define SQW_F_PRESC        5:4
`define SQW_F_THRESH       3:2
`define SQW_F_ACTION       1:0
`define SQW_F_CODE         7:5
`define SQW_RST_METHOD     8'h40
`define SQW_RST_CODE       3'h0
`define SQW_RST_BYTE       8'h00
`define SQW_THR_FIRST      4'h1
`define SQW_THR_FIFTH      4'h5
`define SQW_THR_NINTH      4'h9
`define SQW_ERR_MAX        4'hf
`define SQW_MASK_R3        8'hff
`define SQW_MASK_R2        8'h0f
`define SQW_MASK_R1        8'hf0
`define SQW_MASK_R0        8'h00
`define SQW_ANSWERS        128'hfe_b1_e8_a7_74_3b_62_2d_d3_9c_c5_8a_59_16_4f_00
`define SQW_Q_SEED         4'h1
`define SQW_Q_WRAP         4'hf
`define SQW_Q_PRIOR3       4'h7
`define SQW_AV_CMD         4'h0
`define SQW_AV_STATUS      4'h4
`define SQW_STEP_LAST_BIT  6'h20
`define SQW_STEP_CS_HIGH   6'h21
`define SQW_STEP_DONE      6'h22
`endif

// File: shared/sqw_link_if.sv
`timescale 1ns/1ns
interface sqw_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev  (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : sqw_link_if

// File: shared/sqw_pkg.sv
package sqw_pkg;
  typedef enum logic [1:0] {
    SQW_M_AUTO    = 2'b00,
    SQW_M_TIMEOUT = 2'b01,
    SQW_M_WINDOW  = 2'b10,
    SQW_M_QUIZ    = 2'b11
  } sqw_method_t;
  typedef enum logic [1:0] {
    SQW_PH_FIRST  = 2'b01,
    SQW_PH_SECOND = 2'b10
  } sqw_phase_t;
  typedef enum logic [1:0] {
    SQW_H_IDLE = 2'b01,
    SQW_H_RUN  = 2'b10
  } sqw_host_state_t;
endpackage : sqw_pkg

// File: src/sqw_device.sv
`timescale 1ns/1ns
`include "sqw_defs.svh"
module sqw_device #(
  parameter int P_CYCLES_PER_MS = `SQW_MS_NS / `SQW_CLK_NS
) (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  sqw_link_if.dev         link,
  input  wire logic       i_standby,
  input  wire logic       i_mode_change,
  input  wire logic       i_wake_event,
  input  wire logic       i_wake_clear,
  output logic            o_rxd,
  output logic            o_fail_irq,
  output logic            o_fail_rst,
  output logic      [3:0] o_err_count
);
  localparam logic [23:0] CYC_LAST = 24'(P_CYCLES_PER_MS - 1);

  logic        cs_meta, cs_s, cs_d;
  logic        sclk_meta, sclk_s, sclk_d;
  logic        mosi_meta, mosi_s;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_sh;
  logic [7:0]  tx_sh;
  logic        rise, fall, wr_stb;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  dog_method_and_action;
  logic [2:0]  period_code;
  logic [7:0]  dog_fail_pulse_width;
  logic [7:0]  quiz_setup;
  logic [3:0]  prompt_value_bits;
  logic [3:0]  q_count;
  logic [7:0]  expect_byte;
  logic [1:0]  reply_index_count;
  sqw_pkg::sqw_method_t method;
  sqw_pkg::sqw_method_t eff_method;
  sqw_pkg::sqw_phase_t  phase;
  logic [14:0] half_ms;
  logic [14:0] ms_cnt;
  logic [23:0] cyc_cnt;
  logic        started, halted, wake_flag, active, run, tick, expiry;
  logic        trig_wr, reply_wr, wake_trig, trigger, timing_change;
  logic        byte_ok, byte_bad, quiz_good;
  logic        good_evt, bad_evt, restart;
  logic [3:0]  threshold;

  // ==========================================
  // Period table
  function automatic logic [14:0] period_ms(input logic [2:0] code, input logic [1:0] pre);
    logic [59:0] row;
    row = 60'h0;
    case (code)
      3'h0:    row = {15'h0010, 15'h000c, 15'h0008, 15'h0004};
      3'h1:    row = {15'h0080, 15'h0060, 15'h0040, 15'h0020};
      3'h2:    row = {15'h0200, 15'h0180, 15'h0100, 15'h0080};
      3'h3:    row = {15'h0300, 15'h0200, 15'h0180, 15'h0100};
      3'h4:    row = {15'h0800, 15'h0600, 15'h0400, 15'h0200};
      3'h5:    row = {15'h2000, 15'h1800, 15'h1000, 15'h0800};
      3'h6:    row = {15'h0000, 15'h0000, 15'h4f10, 15'h2800};
      default: row = 60'h0;
    endcase
    period_ms = row[15 * pre +: 15];
  endfunction : period_ms

  // ==========================================
  // Serial slave, all input pins through two flops
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_meta <= 1'b1; cs_s <= 1'b1; cs_d <= 1'b1;
      sclk_meta <= 1'b0; sclk_s <= 1'b0; sclk_d <= 1'b0;
      mosi_meta <= 1'b0; mosi_s <= 1'b0;
    end else begin
      cs_meta <= link.cs_n; cs_s <= cs_meta; cs_d <= cs_s;
      sclk_meta <= link.sclk; sclk_s <= sclk_meta; sclk_d <= sclk_s;
      mosi_meta <= link.mosi; mosi_s <= mosi_meta;
    end
  end

  assign rise    = sclk_s && !sclk_d && !cs_s;
  assign fall    = !sclk_s && sclk_d && !cs_s;
  assign wr_addr = rx_sh[14:8];
  assign wr_data = rx_sh[7:0];
  // Only whole frames count; stray frames between bytes do nothing
  assign wr_stb  = cs_s && !cs_d && bit_cnt == `SQW_FRAME_BITS && rx_sh[15];

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case (a)
      `SQW_ADDR_METHOD: reg_read = dog_method_and_action;
      `SQW_ADDR_PERIOD: reg_read = {period_code, 1'b0, o_err_count};
      `SQW_ADDR_PULSE:  reg_read = dog_fail_pulse_width;
      `SQW_ADDR_QUIZ:   reg_read = quiz_setup;
      `SQW_ADDR_PROMPT: reg_read = {4'h0, prompt_value_bits};
      default:          reg_read = 8'h00;
    endcase
  endfunction : reg_read

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt   <= 5'h0;
      rx_sh     <= 16'h0;
      tx_sh     <= 8'h0;
      link.miso <= 1'b0;
    end else if (cs_s) begin
      bit_cnt   <= 5'h0;
      link.miso <= 1'b0;
    end else begin
      if (rise) begin
        rx_sh <= {rx_sh[14:0], mosi_s};
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h1;
        end
        if (bit_cnt == 5'h7) begin
          tx_sh <= reg_read({rx_sh[5:0], mosi_s});
        end
      end
      if (fall && bit_cnt >= 5'h8) begin
        link.miso <= tx_sh[7];
        tx_sh     <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // ==========================================
  // Register file
  assign timing_change = wr_stb && active
    && ((wr_addr == `SQW_ADDR_METHOD && wr_data[`SQW_F_PRESC] != dog_method_and_action[`SQW_F_PRESC])
    || (wr_addr == `SQW_ADDR_PERIOD && wr_data[`SQW_F_CODE] != period_code));
  assign trig_wr  = wr_stb && wr_addr == `SQW_ADDR_TRIGGER;
  assign reply_wr = wr_stb && wr_addr == `SQW_ADDR_REPLY;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dog_method_and_action <= `SQW_RST_METHOD;
      period_code           <= `SQW_RST_CODE;
      dog_fail_pulse_width  <= `SQW_RST_BYTE;
      quiz_setup            <= `SQW_RST_BYTE;
    end else if (wr_stb) begin
      case (wr_addr)
        `SQW_ADDR_METHOD: dog_method_and_action <= wr_data;
        `SQW_ADDR_PERIOD: period_code <= wr_data[`SQW_F_CODE];
        `SQW_ADDR_PULSE:  dog_fail_pulse_width <= wr_data;
        `SQW_ADDR_QUIZ:   quiz_setup <= wr_data;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Enable, halt and wake handling
  assign method     = sqw_pkg::sqw_method_t'(dog_method_and_action[`SQW_F_METHOD]);
  // Standby falls back to time-out unless autonomous was chosen
  assign eff_method = (i_standby && method != sqw_pkg::SQW_M_AUTO) ? sqw_pkg::SQW_M_TIMEOUT : method;
  assign wake_trig  = method == sqw_pkg::SQW_M_AUTO && i_standby && i_wake_event;
  assign trigger    = trig_wr || wake_trig;
  assign active     = started || (method == sqw_pkg::SQW_M_AUTO && !i_standby);
  assign half_ms    = period_ms(period_code, dog_method_and_action[`SQW_F_PRESC]) >> 1;
  // Reserved codes give a zero period and simply park the timer
  assign run        = active && !halted && half_ms != 15'h0;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      started <= 1'b0;
    end else if (i_mode_change || wake_trig) begin
      started <= 1'b1;
    end else if (i_wake_clear && i_standby) begin
      started <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      halted <= 1'b0;
    end else if (timing_change) begin
      halted <= 1'b1;
    end else if (!active || trigger || reply_wr || i_mode_change) begin
      halted <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_flag <= 1'b0;
      o_rxd     <= 1'b1;
    end else begin
      if (i_wake_event) begin
        wake_flag <= 1'b1;
      end else if (i_wake_clear) begin
        wake_flag <= 1'b0;
      end
      o_rxd <= !(i_standby && wake_flag);
    end
  end

  // ==========================================
  // Window timer
  assign tick   = cyc_cnt == CYC_LAST;
  assign expiry = run && tick && ms_cnt == half_ms - 15'h1 && phase == sqw_pkg::SQW_PH_SECOND;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_cnt <= 24'h0;
      ms_cnt  <= 15'h0;
      phase   <= sqw_pkg::SQW_PH_FIRST;
    end else if (restart || !run) begin
      cyc_cnt <= 24'h0;
      ms_cnt  <= 15'h0;
      phase   <= sqw_pkg::SQW_PH_FIRST;
    end else if (tick) begin
      cyc_cnt <= 24'h0;
      if (ms_cnt == half_ms - 15'h1) begin
        ms_cnt <= 15'h0;
        phase  <= sqw_pkg::SQW_PH_SECOND;
      end else begin
        ms_cnt <= ms_cnt + 15'h1;
      end
    end else begin
      cyc_cnt <= cyc_cnt + 24'h1;
    end
  end

  // ==========================================
  // Quiz replies
  assign byte_ok  = reply_wr && run && eff_method == sqw_pkg::SQW_M_QUIZ && wr_data == expect_byte
    && ((reply_index_count != 2'h3) == (phase == sqw_pkg::SQW_PH_FIRST));
  assign quiz_good = byte_ok && reply_index_count == 2'h3 && q_count == `SQW_Q_PRIOR3;
  assign byte_bad = (reply_wr && !byte_ok) || (restart && !quiz_good);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reply_index_count <= 2'h0;
    end else if (restart) begin
      reply_index_count <= 2'h0;
    end else if (reply_wr && run && eff_method == sqw_pkg::SQW_M_QUIZ) begin
      reply_index_count <= reply_index_count + 2'h1;
    end
  end

  sqw_prompt_gen u_prompt (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_byte_ok  (byte_ok),
    .i_byte_bad (byte_bad),
    .i_index    (reply_index_count),
    .o_prompt   (prompt_value_bits),
    .o_count    (q_count),
    .o_expect   (expect_byte)
  );

  // ==========================================
  // Trigger judgement
  always_comb begin
    good_evt = 1'b0;
    bad_evt  = 1'b0;
    restart  = 1'b0;
    if (i_mode_change) begin
      restart = 1'b1;
    end else if (halted) begin
      restart = trigger || reply_wr;
    end else if (run) begin
      case (eff_method)
        sqw_pkg::SQW_M_WINDOW: begin
          if (trig_wr) begin
            restart  = 1'b1;
            good_evt = phase == sqw_pkg::SQW_PH_SECOND;
            bad_evt  = phase == sqw_pkg::SQW_PH_FIRST;
          end
        end
        sqw_pkg::SQW_M_QUIZ: begin
          if (reply_wr && reply_index_count == 2'h3) begin
            restart  = 1'b1;
            good_evt = quiz_good;
            bad_evt  = !quiz_good;
          end
        end
        default: begin
          if (trigger) begin
            restart  = 1'b1;
            good_evt = 1'b1;
          end
        end
      endcase
      if (expiry && !restart) begin
        restart = 1'b1;
        bad_evt = 1'b1;
      end
    end
  end

  // ==========================================
  // Error counter and failure action
  always_comb begin
    case (dog_method_and_action[`SQW_F_THRESH])
      2'h0:    threshold = `SQW_THR_FIRST;
      2'h1:    threshold = `SQW_THR_FIFTH;
      default: threshold = `SQW_THR_NINTH;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_err_count <= 4'h0;
      o_fail_irq  <= 1'b0;
      o_fail_rst  <= 1'b0;
    end else begin
      o_fail_irq <= 1'b0;
      o_fail_rst <= 1'b0;
      if (bad_evt && o_err_count + 4'h1 >= threshold) begin
        o_err_count <= 4'h0;
        o_fail_irq  <= dog_method_and_action[0];
        o_fail_rst  <= dog_method_and_action[1];
      end else if (bad_evt && o_err_count != `SQW_ERR_MAX) begin
        o_err_count <= o_err_count + 4'h1;
      end else if (good_evt && o_err_count != 4'h0) begin
        o_err_count <= o_err_count - 4'h1;
      end
    end
  end
endmodule : sqw_device

// File: src/sqw_host.sv
`timescale 1ns/1ns
`include "sqw_defs.svh"
module sqw_host (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  sqw_link_if.host         link
);
  localparam logic [3:0] HALF_LAST = 4'(`SQW_SCLK_HALF_NS / `SQW_CLK_NS - 1);

  sqw_pkg::sqw_host_state_t state;
  logic [15:0] cmd;
  logic [15:0] tx_sh;
  logic [7:0]  rx;
  logic [5:0]  step;
  logic [5:0]  next_step;
  logic [3:0]  div;
  logic        miso_meta;
  logic        miso_s;
  logic        start;

  // ==========================================
  // Avalon slave, one wait state per access
  assign start = i_avs_write && !o_avs_waitrequest && i_avs_address == `SQW_AV_CMD
                 && state == sqw_pkg::SQW_H_IDLE;
  assign next_step = step + 6'h1;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && o_avs_waitrequest) begin
      case (i_avs_address)
        `SQW_AV_CMD:    o_avs_readdata <= {16'h0, cmd};
        `SQW_AV_STATUS: o_avs_readdata <= {23'h0, state == sqw_pkg::SQW_H_RUN, rx};
        default:        o_avs_readdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // Link side; read data resynchronised first
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      miso_meta <= 1'b0;
      miso_s    <= 1'b0;
    end else begin
      miso_meta <= link.miso;
      miso_s    <= miso_meta;
    end
  end

  // Half period is long so that the device reply settles through both synchronisers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state     <= sqw_pkg::SQW_H_IDLE;
      cmd       <= 16'h0;
      tx_sh     <= 16'h0;
      rx        <= 8'h0;
      step      <= 6'h0;
      div       <= 4'h0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end else if (start) begin
      state     <= sqw_pkg::SQW_H_RUN;
      cmd       <= i_avs_writedata[15:0];
      tx_sh     <= {i_avs_writedata[14:0], 1'b0};
      step      <= 6'h0;
      div       <= 4'h0;
      link.cs_n <= 1'b0;
      link.mosi <= i_avs_writedata[15];
    end else if (state == sqw_pkg::SQW_H_RUN) begin
      if (div == HALF_LAST) begin
        div  <= 4'h0;
        step <= next_step;
        if (next_step <= `SQW_STEP_LAST_BIT) begin
          if (next_step[0]) begin
            link.sclk <= 1'b1;
            rx        <= {rx[6:0], miso_s};
          end else begin
            link.sclk <= 1'b0;
            link.mosi <= tx_sh[15];
            tx_sh     <= {tx_sh[14:0], 1'b0};
          end
        end else if (next_step == `SQW_STEP_CS_HIGH) begin
          link.cs_n <= 1'b1;
        end else if (next_step == `SQW_STEP_DONE) begin
          state <= sqw_pkg::SQW_H_IDLE;
        end
      end else begin
        div <= div + 4'h1;
      end
    end
  end
endmodule : sqw_host

// File: src/sqw_prompt_gen.sv
`timescale 1ns/1ns
`include "sqw_defs.svh"
module sqw_prompt_gen (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_byte_ok,
  input  wire logic       i_byte_bad,
  input  wire logic [1:0] i_index,
  output logic      [3:0] o_prompt,
  output logic      [3:0] o_count,
  output logic      [7:0] o_expect
);
  localparam logic [127:0] ANSWERS = `SQW_ANSWERS;

  // ==========================================
  // Question state machine
  // Stand-in polynomial; swap when real taps arrive
  function automatic logic [3:0] next_prompt(input logic [3:0] y);
    if (y == 4'h0) begin
      next_prompt = `SQW_Q_SEED;
    end else begin
      next_prompt = {y[2:0], y[3] ^ y[2]};
    end
  endfunction : next_prompt

  // Thermometer of correct bytes; full means good reply
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_count <= 4'h0;
    end else if (o_count == `SQW_Q_WRAP) begin
      o_count <= 4'h0;
    end else if (i_byte_bad) begin
      o_count <= 4'h0;
    end else if (i_byte_ok) begin
      o_count <= {o_count[2:0], 1'b1};
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prompt <= 4'h0;
    end else if (o_count == `SQW_Q_WRAP) begin
      o_prompt <= next_prompt(o_prompt);
    end
  end

  // ==========================================
  // Expected reply bytes, highest response first
  always_comb begin
    o_expect = ANSWERS[8 * o_prompt +: 8];
    case (i_index)
      2'h0:    o_expect = o_expect ^ `SQW_MASK_R3;
      2'h1:    o_expect = o_expect ^ `SQW_MASK_R2;
      2'h2:    o_expect = o_expect ^ `SQW_MASK_R1;
      default: o_expect = o_expect ^ `SQW_MASK_R0;
    endcase
  end
endmodule : sqw_prompt_gen

// File: test/sqw_link_sva.sv
`timescale 1ns/1ns
module sqw_link_sva (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  // ==========
  // Rises per frame
  logic [5:0] rises;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) rises <= 6'h00;
    else if (cs_n) rises <= 6'h00;
    else if ($rose(sclk)) rises <= rises + 6'h01;
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  // ==========
  // Link framing
  a_idle_sclk_low: assert property (cs_n |-> !sclk)
    else $error("sclk moved outside a frame");
  a_miso_quiet: assert property (cs_n [*4] |-> !miso)
    else $error("miso driven while deselected");
  a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase not 8 clocks");
  a_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low phase too short");
  a_mosi_held: assert property ($rose(sclk) |-> $stable(mosi) [*8])
    else $error("mosi changed while sclk high");
  a_first_edge: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first sclk rise misplaced");
  a_gap_len: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("frame gap too short");
  a_frame_bits: assert property ($rose(cs_n) |-> rises == 6'h10)
    else $error("frame not 16 bits");
  a_miso_mode0: assert property (!cs_n && $changed(miso) |-> !sclk)
    else $error("miso changed while sclk high");
  c_frame: cover property ($rose(cs_n) && rises == 6'h10);
  c_miso_one: cover property ($rose(sclk) && miso);
  c_back_to_back: cover property ($rose(cs_n) ##[4:60] $fell(cs_n));
endmodule : sqw_link_sva

// File: test/tb.sv
`timescale 1ns/1ns
module tb;
  logic        i_clock = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_standby = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  i_avs_address = 4'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        o_rxd;
  logic        o_fail_irq;
  logic        o_fail_rst;
  logic [3:0]  o_err_count;
  logic [31:0] q;
  logic [7:0]  r;
  int          err_total = 0;
  int          checks = 0;
  int          n;
  int          e;
  sqw_link_if link ();
  sqw_host sqw_host_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .link(link.host));
  // Short ms keeps quiz cycles near 5000 clocks
  sqw_device #(.P_CYCLES_PER_MS(10)) sqw_device_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .link(link.dev), .i_standby(i_standby), .i_mode_change(ev[0]), .i_wake_event(ev[1]),
    .i_wake_clear(ev[2]), .o_rxd(o_rxd), .o_fail_irq(o_fail_irq), .o_fail_rst(o_fail_rst),
    .o_err_count(o_err_count));
  sqw_link_sva sqw_link_sva_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
  always #50 i_clock = ~i_clock;
  // ==========
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    err_total++;
    $display("wrong value at %0t ns: wait ran out", $time);
    tally_and_finish();
  endtask : hang
  task automatic tick(input int c);
    repeat (c) @(posedge i_clock);
  endtask : tick
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) hang();
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : av
  task automatic spi(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int k;
    k = 0;
    av(1'b1, 4'h0, {16'h0, wr, a, d});
    do begin
      av(1'b0, 4'h4, 32'h0);
      k++;
    end while (q[8] !== 1'b0 && k < 200);
    if (k >= 200) hang();
    r = q[7:0];
  endtask : spi
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge i_clock);
    ev[b] <= 1'b0;
  endtask : pulse
  // Three bytes early, last one deep in the second half
  task automatic quiz(input logic [31:0] a, input logic [3:0] p);
    spi(1'b1, 7'h2e, a[31:24]);
    spi(1'b1, 7'h2e, a[23:16]);
    spi(1'b0, 7'h2f, 8'h00);
    chk(32'(r), 32'(p));
    spi(1'b1, 7'h2e, a[15:8]);
    tick(1800);
    e = o_err_count;
    spi(1'b1, 7'h2e, a[7:0]);
    tick(2);
  endtask : quiz
  // ==========
  // Sequence
  initial begin
    tick(16);
    i_sys_rst <= 1'b0;
    chk(32'(o_rxd), 32'h1);
    av(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    spi(1'b0, 7'h13, 8'h00);
    chk(32'(r), 32'h40);
    spi(1'b0, 7'h2f, 8'h00);
    chk(32'(r), 32'h0);
    for (int m = 0; m < 4; m++) begin
      spi(1'b1, 7'h13, {m[1:0], 6'h00});
      spi(1'b0, 7'h13, 8'h00);
      chk(32'(r), 32'(m << 6));
    end
    av(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1300);
    spi(1'b1, 7'h13, 8'h47);
    pulse(0);
    n = 0;
    while (o_fail_irq !== 1'b1 && n < 400) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 400) hang();
    chk(32'(o_fail_rst), 32'h1);
    chk(32'(n >= 190 && n <= 215), 32'h1);
    tick(1);
    chk(32'(o_err_count), 32'h0);
    spi(1'b1, 7'h14, 8'h2f);
    e = o_err_count;
    spi(1'b0, 7'h14, 8'h00);
    chk(32'(r), {24'h0, 4'h2, 4'(e)});
    tick(800);
    chk(32'(o_err_count), 32'(e));
    spi(1'b1, 7'h15, 8'h00);
    e = o_err_count;
    spi(1'b1, 7'h15, 8'h00);
    chk(32'(o_err_count), 32'((e > 0) ? e - 1 : 0));
    e = o_err_count;
    tick(300);
    chk(32'(o_err_count), 32'(e));
    tick(40);
    chk(32'(o_err_count), 32'((e == 4) ? 0 : e + 1));
    spi(1'b1, 7'h14, 8'h40);
    spi(1'b1, 7'h13, 8'h88);
    pulse(0);
    e = o_err_count;
    spi(1'b1, 7'h15, 8'h00);
    chk(32'(o_err_count), 32'(e + 1));
    tick(150);
    spi(1'b1, 7'h15, 8'h00);
    chk(32'(o_err_count), 32'(e + 2));
    tick(400);
    spi(1'b1, 7'h15, 8'h00);
    chk(32'(o_err_count), 32'(e + 1));
    tick(1200);
    chk(32'(o_err_count), 32'(e + 1));
    tick(100);
    chk(32'(o_err_count), 32'(e + 2));
    spi(1'b1, 7'h13, 8'hf8);
    pulse(0);
    quiz(32'hff0ff000, 4'h0);
    chk(32'(o_err_count), 32'((e > 0) ? e - 1 : 0));
    spi(1'b0, 7'h2f, 8'h00);
    chk(32'(r), 32'h1);
    quiz(32'hb040bf00, 4'h1);
    chk(32'(o_err_count), 32'(e + 1));
    spi(1'b0, 7'h2f, 8'h00);
    chk(32'(r), 32'h1);
    quiz(32'hb040bf4f, 4'h1);
    chk(32'(o_err_count), 32'(e - 1));
    spi(1'b0, 7'h2f, 8'h00);
    chk(32'(r), 32'h2);
    spi(1'b1, 7'h13, 8'h08);
    i_standby <= 1'b1;
    tick(2);
    pulse(1);
    tick(2);
    chk(32'(o_rxd), 32'h0);
    pulse(2);
    tick(2);
    chk(32'(o_rxd), 32'h1);
    e = o_err_count;
    tick(1400);
    chk(32'(o_err_count), 32'(e));
    tally_and_finish();
  end
endmodule : tb
